// ### shared/alc_regs.vh
// Overview of operation
// R01 - Rate field must match ADC rate: 00 96k, 01 48k, 10 32k; 11 reserved.
// R02 - Step limit field codes 00..11 select recovery step limits 3, 7, 15, 31.
// R03 - Recovery mode: 00 none, 01 normal, 10 limited, 11 reserved.
// R04 - Limit-detect 0: reduce gain when either channel exceeds the limit.
// R05 - Limit-detect 1: reduce gain only when both channels exceed together.
// R06 - Enable bit 0 of config register turns level control on or off.
// R07 - Recovery threshold codes select -2, -3, -4, -6 dB.
// R08 - Attack threshold codes select 0, -1, -2, -4 dB.
// R09 - Recovery time codes select 32, 64, 128, 256 ms.
// R10 - Attack time bit selects 1 ms when 0, 4 ms when 1.
// R11 - Any write to restart register restarts level control, data ignored.
// R12 - Reading restart register returns gain reduction and does not restart.
// R13 - Crystal oscillator keeps running while device is held in reset.
// R14 - S/PDIF receiver oscillator stays active while device is in reset.
// R15 - Limited mode counts recovery steps, stops at limit until restart.
// R16 - Reduce gain after attack time over threshold; recover in steps after.
`ifndef ALC_REGS_VH
`define ALC_REGS_VH

`define ALC_ADDR_CONFIG      7'h7B
`define ALC_ADDR_THRESH      7'h7C
`define ALC_ADDR_RESTART     7'h7D

`define ALC_CONFIG_RESET     8'h00
`define ALC_THRESH_RESET     8'h00

// Config register fields
`define ALC_BIT_ENABLE       0
`define ALC_BIT_BOTH         1
`define ALC_RMODE_LSB        2
`define ALC_STEPLIM_LSB      4
`define ALC_RATE_LSB         6

// Threshold register fields
`define ALC_BIT_ATIME        0
`define ALC_RTIME_LSB        1
`define ALC_ATHR_LSB         3
`define ALC_RTHR_LSB         5

`define ALC_RATE_96K         2'h0
`define ALC_RATE_48K         2'h1
`define ALC_RATE_32K         2'h2

// Samples per millisecond at each rate
`define ALC_SPMS_96K         8'h60
`define ALC_SPMS_48K         8'h30
`define ALC_SPMS_32K         8'h20

`define ALC_MODE_NONE        2'h0
`define ALC_MODE_NORMAL      2'h1
`define ALC_MODE_LIMITED     2'h2

`define ALC_STEPLIM_0        5'h03
`define ALC_STEPLIM_1        5'h07
`define ALC_STEPLIM_2        5'h0F
`define ALC_STEPLIM_3        5'h1F

// Thresholds as dB below full scale
`define ALC_RTHR_0           8'h02
`define ALC_RTHR_1           8'h03
`define ALC_RTHR_2           8'h04
`define ALC_RTHR_3           8'h06
`define ALC_ATHR_0           8'h00
`define ALC_ATHR_1           8'h01
`define ALC_ATHR_2           8'h02
`define ALC_ATHR_3           8'h04

// Times in milliseconds
`define ALC_RTIME_0          9'h020
`define ALC_RTIME_1          9'h040
`define ALC_RTIME_2          9'h080
`define ALC_RTIME_3          9'h100
`define ALC_ATIME_0          9'h001
`define ALC_ATIME_1          9'h004

`endif

// ### verilog/alc_ms_timer.v
`timescale 1ns/1ns
// Counts millisecond ticks while a condition holds; pulses once per period.
module alc_ms_timer #(
  parameter W = 9
) (
  input  wire         i_clk_sys,  // System clock
  input  wire         i_sys_rst,  // Sync reset, active high
  input  wire         i_clear,    // Restart count
  input  wire         i_run,      // Condition holds
  input  wire         i_tick,     // Millisecond tick
  input  wire [W-1:0] i_period,   // Period in ms, at least 1
  output reg          o_done      // One-cycle pulse at period end
);
  reg [W-1:0] count;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst || i_clear || !i_run) begin
      count  <= {W{1'b0}};
      o_done <= 1'b0;
    end else if (i_tick) begin
      if (count == i_period - {{(W-1){1'b0}}, 1'b1}) begin
        count  <= {W{1'b0}};
        o_done <= 1'b1;
      end else begin
        count  <= count + {{(W-1){1'b0}}, 1'b1};
        o_done <= 1'b0;
      end
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule // alc_ms_timer

// ### verilog/alc_level_ctrl.v
`timescale 1ns/1ns
`include "alc_regs.vh"
module alc_level_ctrl #(
  parameter GR_MAX = 8'hFF
) (
  input  wire       i_clk_sys,          // System clock, 50 MHz
  input  wire       i_sys_rst,          // Sync reset, active high
  input  wire [6:0] i_reg_addr,         // Register address
  input  wire       i_reg_wr,           // Write strobe, one cycle
  input  wire       i_reg_rd,           // Read strobe, one cycle
  input  wire [7:0] i_reg_wdata,        // Write data
  input  wire       i_sample_valid,     // ADC sample strobe
  input  wire [7:0] i_left_peak_db,     // Left peak, dB below full scale
  input  wire [7:0] i_right_peak_db,    // Right peak, dB below full scale
  input  wire       i_spdif_powerdown,  // Receiver power-down request
  output reg  [7:0] o_reg_rdata,        // Read data, valid after read
  output reg  [7:0] o_gain_reduction,   // Current gain reduction steps
  output reg        o_alc_active,       // Level control running
  output reg        o_crystal_osc_run,  // Oscillator on crystal pins runs
  output reg        o_spdif_vco_run     // Receiver oscillator runs
);
  reg  [7:0] level_control_config;
  reg  [7:0] level_control_thresholds;
  reg  [7:0] ms_count;
  reg        ms_tick;
  reg  [4:0] step_count;
  reg        restart;
  reg  [7:0] spms;
  reg  [4:0] step_limit;
  reg  [7:0] rec_db;
  reg  [7:0] att_db;
  reg  [8:0] rec_ms;
  reg  [8:0] att_ms;
  reg  [7:0] next_gain;
  reg  [4:0] next_steps;
  wire       enable;
  wire       both_mode;
  wire [1:0] rate_sel;
  wire [1:0] mode_sel;
  wire       left_over;
  wire       right_over;
  wire       over;
  wire       below;
  wire       att_done;
  wire       rec_done;
  wire       rec_allowed;

  assign enable    = level_control_config[`ALC_BIT_ENABLE];
  assign both_mode = level_control_config[`ALC_BIT_BOTH];
  assign mode_sel  = level_control_config[`ALC_RMODE_LSB+1:`ALC_RMODE_LSB];
  assign rate_sel  = level_control_config[`ALC_RATE_LSB+1:`ALC_RATE_LSB];

  // Decode of field codes into working values
  always @* begin
    case (rate_sel) // [R01]
      `ALC_RATE_96K: spms = `ALC_SPMS_96K;
      `ALC_RATE_48K: spms = `ALC_SPMS_48K;
      `ALC_RATE_32K: spms = `ALC_SPMS_32K;
      // Reserved code falls back to 48k so the divider never stalls
      default:       spms = `ALC_SPMS_48K;
    endcase
    case (level_control_config[`ALC_STEPLIM_LSB+1:`ALC_STEPLIM_LSB]) // [R02]
      2'h0:    step_limit = `ALC_STEPLIM_0;
      2'h1:    step_limit = `ALC_STEPLIM_1;
      2'h2:    step_limit = `ALC_STEPLIM_2;
      default: step_limit = `ALC_STEPLIM_3;
    endcase
  end

  // Threshold codes to dB below full scale
  always @* begin
    case (level_control_thresholds[`ALC_RTHR_LSB+1:`ALC_RTHR_LSB]) // [R07]
      2'h0:    rec_db = `ALC_RTHR_0;
      2'h1:    rec_db = `ALC_RTHR_1;
      2'h2:    rec_db = `ALC_RTHR_2;
      default: rec_db = `ALC_RTHR_3;
    endcase
    case (level_control_thresholds[`ALC_ATHR_LSB+1:`ALC_ATHR_LSB]) // [R08]
      2'h0:    att_db = `ALC_ATHR_0;
      2'h1:    att_db = `ALC_ATHR_1;
      2'h2:    att_db = `ALC_ATHR_2;
      default: att_db = `ALC_ATHR_3;
    endcase
  end

  // Time codes to milliseconds
  always @* begin
    case (level_control_thresholds[`ALC_RTIME_LSB+1:`ALC_RTIME_LSB])
      2'h0:    rec_ms = `ALC_RTIME_0; // [R09]
      2'h1:    rec_ms = `ALC_RTIME_1;
      2'h2:    rec_ms = `ALC_RTIME_2;
      default: rec_ms = `ALC_RTIME_3;
    endcase
    if (level_control_thresholds[`ALC_BIT_ATIME]) begin // [R10]
      att_ms = `ALC_ATIME_1;
    end else begin
      att_ms = `ALC_ATIME_0;
    end
  end

  // Smaller dB-below-FS value means a louder signal
  assign left_over  = (i_left_peak_db <= att_db);
  assign right_over = (i_right_peak_db <= att_db);
  assign over  = both_mode ? (left_over && right_over)  // [R05]
                           : (left_over || right_over); // [R04]
  assign below = (i_left_peak_db > rec_db) && (i_right_peak_db > rec_db);

  // Register port; restart fires on write only, never on read
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      level_control_config     <= `ALC_CONFIG_RESET;
      level_control_thresholds <= `ALC_THRESH_RESET;
      restart                  <= 1'b0;
      o_reg_rdata              <= 8'h00;
    end else begin
      restart <= i_reg_wr && (i_reg_addr == `ALC_ADDR_RESTART); // [R11]
      if (i_reg_wr && i_reg_addr == `ALC_ADDR_CONFIG) begin
        level_control_config <= i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == `ALC_ADDR_THRESH) begin
        level_control_thresholds <= {1'b0, i_reg_wdata[6:0]};
      end
      if (i_reg_rd) begin
        case (i_reg_addr)
          `ALC_ADDR_CONFIG:  o_reg_rdata <= level_control_config;
          `ALC_ADDR_THRESH:  o_reg_rdata <= level_control_thresholds;
          `ALC_ADDR_RESTART: o_reg_rdata <= o_gain_reduction; // [R12]
          default:           o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Millisecond tick from the sample strobe at the programmed rate
  always @(posedge i_clk_sys) begin
    if (i_sys_rst || !enable || restart) begin
      ms_count <= 8'h00;
      ms_tick  <= 1'b0;
    end else if (i_sample_valid) begin
      if (ms_count >= spms - 8'h01) begin // [R01]
        ms_count <= 8'h00;
        ms_tick  <= 1'b1;
      end else begin
        ms_count <= ms_count + 8'h01;
        ms_tick  <= 1'b0;
      end
    end else begin
      ms_tick <= 1'b0;
    end
  end

  // Timers restart whenever their condition lapses
  alc_ms_timer #(
    .W (9)
  ) u_attack_timer (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (restart),
    .i_run     (enable && over),
    .i_tick    (ms_tick),
    .i_period  (att_ms),
    .o_done    (att_done)
  );

  alc_ms_timer #(
    .W (9)
  ) u_recovery_timer (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_clear   (restart),
    .i_run     (enable && below),
    .i_tick    (ms_tick),
    .i_period  (rec_ms),
    .o_done    (rec_done)
  );

  // Recovery gating per mode; limited mode freezes at the step limit
  assign rec_allowed = (mode_sel == `ALC_MODE_NORMAL) || // [R03]
                       ((mode_sel == `ALC_MODE_LIMITED) &&
                        (step_count < step_limit));     // [R15]

  // Attack outranks recovery when both land together, except with gain already at GR_MAX
  always @* begin
    next_gain  = o_gain_reduction;
    next_steps = step_count;
    if (att_done && o_gain_reduction != GR_MAX) begin // [R16]
      next_gain = o_gain_reduction + 8'h01;
    end else if (rec_done && rec_allowed && o_gain_reduction != 8'h00) begin
      next_gain = o_gain_reduction - 8'h01; // [R16]
      if (mode_sel == `ALC_MODE_LIMITED) begin
        next_steps = step_count + 5'h01; // [R15]
      end
    end
  end

  // Restart outranks a same-cycle step
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_gain_reduction <= 8'h00;
      step_count       <= 5'h00;
      o_alc_active     <= 1'b0;
    end else if (!enable || restart) begin // [R06] [R11]
      o_gain_reduction <= 8'h00;
      step_count       <= 5'h00;
      o_alc_active     <= enable;
    end else begin
      o_gain_reduction <= next_gain;
      step_count       <= next_steps;
      o_alc_active     <= 1'b1; // [R06]
    end
  end

  // Clock circuits stay on through reset for a fast restart
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_crystal_osc_run <= 1'b1; // [R13]
      o_spdif_vco_run   <= 1'b1; // [R14]
    end else begin
      o_crystal_osc_run <= 1'b1;
      o_spdif_vco_run   <= !i_spdif_powerdown;
    end
  end
endmodule // alc_level_ctrl

// ### test/alc_level_ctrl_chk.sv
`timescale 1ns/1ns
module alc_level_chk (
  input wire       i_clk_sys,          // System clock
  input wire       i_sys_rst,          // Sync reset
  input wire [6:0] i_reg_addr,         // Register address
  input wire       i_reg_wr,           // Write strobe
  input wire       i_reg_rd,           // Read strobe
  input wire [7:0] i_reg_wdata,        // Write data
  input wire       i_spdif_powerdown,  // Receiver power-down
  input wire [7:0] o_reg_rdata,        // Read data
  input wire [7:0] o_gain_reduction,   // Gain reduction
  input wire       o_alc_active,       // Level control running
  input wire       o_crystal_osc_run,  // Crystal oscillator runs
  input wire       o_spdif_vco_run     // Receiver oscillator runs
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  wire cfg_wr = i_reg_wr && i_reg_addr == 7'h7B;
  wire rs_wr  = i_reg_wr && i_reg_addr == 7'h7D;
  wire rs_rd  = i_reg_rd && i_reg_addr == 7'h7D;
  // Must hold inside reset as well
  a_crystal_stays_on: assert property (disable iff (1'b0)
    $past(i_sys_rst) |-> o_crystal_osc_run) else $error("crystal stopped");
  a_vco_reset_on: assert property ($fell(i_sys_rst) |-> o_spdif_vco_run)
    else $error("receiver osc off after reset");
  a_vco_follows_pd: assert property (!$past(i_sys_rst) |->
    o_spdif_vco_run == !$past(i_spdif_powerdown)) else $error("osc vs pd");
  a_read_gain_val: assert property (rs_rd |=>
    o_reg_rdata == $past(o_gain_reduction)) else $error("restart read");
  a_restart_clears: assert property (rs_wr |-> ##2
    o_gain_reduction == 8'h00) else $error("restart kept gain");
  a_enable_active: assert property (cfg_wr && i_reg_wdata[0] |->
    ##2 o_alc_active) else $error("enable ignored");
  a_disable_clears: assert property (cfg_wr && !i_reg_wdata[0] |->
    ##[1:3] (o_gain_reduction == 8'h00 && !o_alc_active))
    else $error("disable ignored");
  a_gain_one_step: assert property ($changed(o_gain_reduction) |->
    o_gain_reduction == $past(o_gain_reduction) + 8'h01 ||
    o_gain_reduction == $past(o_gain_reduction) - 8'h01 ||
    o_gain_reduction == 8'h00) else $error("gain jumped");
  c_restart: cover property (rs_wr);
  c_read_gain: cover property (rs_rd && o_gain_reduction != 8'h00);
  c_gain_four: cover property (o_gain_reduction == 8'h04);
endmodule // alc_level_chk
bind alc_level_ctrl alc_level_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .i_spdif_powerdown(i_spdif_powerdown), .o_reg_rdata(o_reg_rdata),
  .o_gain_reduction(o_gain_reduction), .o_alc_active(o_alc_active),
  .o_crystal_osc_run(o_crystal_osc_run), .o_spdif_vco_run(o_spdif_vco_run));

// ### test/alc_level_ctrl_test.sv
`timescale 1ns/1ns
`include "alc_regs.vh"
module alc_level_ctrl_test;
  reg        i_clk_sys, i_sys_rst, i_reg_wr, i_reg_rd;
  reg        i_sample_valid, i_spdif_powerdown;
  reg  [6:0] i_reg_addr;
  reg  [7:0] i_reg_wdata, lpk, rpk, rv;
  wire [7:0] o_reg_rdata, o_gain_reduction;
  wire       o_alc_active, o_crystal_osc_run, o_spdif_vco_run;
  integer    err_total, n_compared;

  alc_level_ctrl uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .i_sample_valid(i_sample_valid),
    .i_left_peak_db(lpk), .i_right_peak_db(rpk),
    .i_spdif_powerdown(i_spdif_powerdown), .o_reg_rdata(o_reg_rdata),
    .o_gain_reduction(o_gain_reduction), .o_alc_active(o_alc_active),
    .o_crystal_osc_run(o_crystal_osc_run), .o_spdif_vco_run(o_spdif_vco_run));

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Strobe dropped, then an idle edge so the next call never re-raises it
  task wr(input [6:0] a, input [7:0] d);
    begin
      @(posedge i_clk_sys);
      i_reg_addr <= a; i_reg_wdata <= d; i_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      repeat (2) @(negedge i_clk_sys);
    end
  endtask

  task rd(input [6:0] a);
    begin
      @(posedge i_clk_sys);
      i_reg_addr <= a; i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      @(negedge i_clk_sys);
      rv = o_reg_rdata;
    end
  endtask

  // Samples every other cycle; peaks held for the whole burst
  task samples(input integer n, input [7:0] l, input [7:0] r);
    begin
      @(posedge i_clk_sys);
      lpk <= l; rpk <= r;
      repeat (n) begin
        @(posedge i_clk_sys); i_sample_valid <= 1'b1;
        @(posedge i_clk_sys); i_sample_valid <= 1'b0;
      end
      repeat (4) @(negedge i_clk_sys);
    end
  endtask

  task wrap_up;
    begin
      $display("mismatches %0d compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_total = err_total + 1;
    wrap_up;
  end

  initial begin
    err_total = 0; n_compared = 0;
    i_sys_rst = 1'b1; i_reg_wr = 1'b0; i_reg_rd = 1'b0; i_reg_addr = 7'h00;
    i_reg_wdata = 8'h00; i_sample_valid = 1'b0; i_spdif_powerdown = 1'b0;
    lpk = 8'h20; rpk = 8'h20;
    repeat (4) @(negedge i_clk_sys);
    chk({7'h00, o_crystal_osc_run}, 8'h01);
    chk({7'h00, o_spdif_vco_run}, 8'h01);
    @(posedge i_clk_sys) i_sys_rst <= 1'b0;
    rd(`ALC_ADDR_CONFIG); chk(rv, 8'h00);
    // Thresholds: recovery -6 dB, attack -4 dB, 32 ms and 1 ms; bit 7 dropped
    wr(`ALC_ADDR_THRESH, 8'hF8);
    rd(`ALC_ADDR_THRESH); chk(rv, 8'h78);
    rd(7'h7E); chk(rv, 8'h00);
    // 32 kHz, limit 3, limited recovery, either channel, enabled
    wr(`ALC_ADDR_CONFIG, 8'h89);
    rd(`ALC_ADDR_CONFIG); chk(rv, 8'h89);
    chk({7'h00, o_alc_active}, 8'h01);
    wr(`ALC_ADDR_RESTART, 8'h5A);
    samples(32, 8'h04, 8'h20); chk(o_gain_reduction, 8'h01);
    samples(96, 8'h04, 8'h20); chk(o_gain_reduction, 8'h04);
    rd(`ALC_ADDR_RESTART); chk(rv, 8'h04);
    repeat (2) @(negedge i_clk_sys);
    chk(o_gain_reduction, 8'h04);
    wr(`ALC_ADDR_CONFIG, 8'h8B);
    samples(64, 8'h04, 8'h05); chk(o_gain_reduction, 8'h04);
    samples(32, 8'h04, 8'h04); chk(o_gain_reduction, 8'h05);
    // Five recovery periods, but only three steps allowed
    samples(5120, 8'h07, 8'h07); chk(o_gain_reduction, 8'h02);
    wr(`ALC_ADDR_RESTART, 8'h00); chk(o_gain_reduction, 8'h00);
    wr(`ALC_ADDR_CONFIG, 8'h83);
    samples(64, 8'h04, 8'h04); chk(o_gain_reduction, 8'h02);
    samples(3072, 8'h07, 8'h07); chk(o_gain_reduction, 8'h02);
    wr(`ALC_ADDR_CONFIG, 8'h82);
    chk(o_gain_reduction, 8'h00);
    chk({7'h00, o_alc_active}, 8'h00);
    @(posedge i_clk_sys) i_spdif_powerdown <= 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk({7'h00, o_spdif_vco_run}, 8'h00);
    @(posedge i_clk_sys) i_sys_rst <= 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk({7'h00, o_crystal_osc_run}, 8'h01);
    chk({7'h00, o_spdif_vco_run}, 8'h01);
    @(posedge i_clk_sys) i_sys_rst <= 1'b0;
    i_spdif_powerdown <= 1'b0;
    rd(`ALC_ADDR_CONFIG); chk(rv, 8'h00);
    // 48 kHz, normal recovery; 0 dB attack over 4 ms, -2 dB recovery
    wr(`ALC_ADDR_THRESH, 8'h01);
    wr(`ALC_ADDR_CONFIG, 8'h45);
    samples(192, 8'h01, 8'h01); chk(o_gain_reduction, 8'h00);
    samples(192, 8'h00, 8'h20); chk(o_gain_reduction, 8'h01);
    samples(1536, 8'h20, 8'h20); chk(o_gain_reduction, 8'h00);
    wrap_up;
  end
endmodule // alc_level_ctrl_test
